// ---- rsc_clock_loss.sv ----
// Clock loss one-shot: times out when the monitored clock heartbeat stops
`timescale 1ns/100ps
module rsc_clock_loss #(
  parameter int LIMIT = rsc_pkg::MCD_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic heartbeat,
  output logic      timeout
);
  import rsc_pkg::*;

  logic [MCD_CNT_W-1:0] cnt_r;
  logic [MCD_CNT_W-1:0] cnt_nxt;
  logic                 beat_r;
  logic                 timeout_r;
  logic                 timeout_nxt;

  // Each heartbeat edge retriggers the one-shot
  always_comb begin
    cnt_nxt     = cnt_r;
    timeout_nxt = 1'b0;
    if (!enable || (heartbeat != beat_r)) begin
      cnt_nxt = '0;
    end else if (cnt_r == MCD_CNT_W'(LIMIT - 1)) begin
      cnt_nxt     = '0;
      timeout_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + MCD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r     <= '0;
      beat_r    <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      beat_r    <= heartbeat;
      timeout_r <= timeout_nxt;
    end
  end

  assign timeout = timeout_r;

  chk_loss_timeout: assert property (@(posedge clk) disable iff (!resetn)
    (cnt_r == MCD_CNT_W'(LIMIT - 1)) && enable && (heartbeat == beat_r) |=> timeout)
    else $error("clock loss timeout not raised");
endmodule

// ---- rsc_controller.sv ----
// Reset source controller: cause capture, reset hold and register access
`timescale 1ns/100ps
module rsc_controller #(
  parameter int MCD_LIMIT = rsc_pkg::MCD_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  rsc_pkg::rsc_sfr_req_t  sfrReq,
  output logic [7:0]             sfrRdata,
  input  wire logic              rstPinIn,
  output logic                   rstPinOut,
  output logic                   rstPinOe,
  input  wire logic              vddAbove,
  input  wire logic              compOut,
  input  wire logic              wdtOverflow,
  input  wire logic              clkHeartbeat,
  input  rsc_pkg::rsc_flash_req_t flashReq,
  output logic                   sysResetn
);
  import rsc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rsc_state_t             state_r;
  rsc_state_t             state_nxt;
  rsc_cause_t             cause_r;
  rsc_cause_t             cause_nxt;
  logic [6:0]             flags_r;
  logic [6:0]             flags_nxt;
  logic [HOLD_CNT_W-1:0]  holdCnt_r;
  logic [HOLD_CNT_W-1:0]  holdCnt_nxt;
  logic                   monEn_r;
  logic                   monEn_nxt;
  logic                   supSrc_r;
  logic                   supSrc_nxt;
  logic                   clkEn_r;
  logic                   clkEn_nxt;
  logic                   compSrc_r;
  logic                   compSrc_nxt;
  logic [7:0]             rdata_r;
  logic [7:0]             rdata_nxt;
  logic                   pinOe_r;
  logic                   pinOe_nxt;
  logic                   sysRst_r;
  logic                   sysRst_nxt;

  logic       supplyTrip;
  logic       pinTrip;
  logic       compTrip;
  logic       softTrip;
  logic       lossPulse;
  logic       flashFault;
  logic       anyTrip;
  logic       causeLive;
  rsc_cause_t tripCause;
  logic       monWrite;
  logic       causeWrite;

  // ---------------------------------------------------------------
  // Cause detectors
  // ---------------------------------------------------------------
  rsc_clock_loss #(
    .LIMIT (MCD_LIMIT)
  ) i_rsc_clock_loss (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (clkEn_r && (state_r == ST_RUN)),
    .heartbeat (clkHeartbeat),
    .timeout   (lossPulse)
  );

  rsc_flash_guard i_rsc_flash_guard (
    .clk    (clk),
    .resetn (resetn),
    .req    (flashReq),
    .fault  (flashFault)
  );

  // Full 8-bit address decode: each register answers at its one address only
  assign monWrite   = sfrReq.wr && (sfrReq.addr == MON_CTRL_ADDR);
  assign causeWrite = sfrReq.wr && (sfrReq.addr == CAUSE_ADDR);

  assign supplyTrip = monEn_r && supSrc_r && !vddAbove;
  // Own pin drive must not read back as an external reset
  assign pinTrip    = !rstPinIn && !pinOe_r;
  assign compTrip   = compSrc_r && !compOut;
  assign softTrip   = causeWrite && sfrReq.wdata[SOFT_BIT];

  // ---------------------------------------------------------------
  // Trip priority
  // ---------------------------------------------------------------
  always_comb begin
    anyTrip   = 1'b1;
    tripCause = CAUSE_POWER;
    if (supplyTrip) begin
      tripCause = CAUSE_POWER;
    end else if (pinTrip) begin
      tripCause = CAUSE_PIN;
    end else if (lossPulse) begin
      tripCause = CAUSE_CLK;
    end else if (compTrip) begin
      tripCause = CAUSE_COMP;
    end else if (wdtOverflow) begin
      tripCause = CAUSE_WDT;
    end else if (flashFault) begin
      tripCause = CAUSE_FLASH;
    end else if (softTrip) begin
      tripCause = CAUSE_SOFT;
    end else begin
      anyTrip = 1'b0;
    end
  end

  // Conditions that keep the device in reset past the minimum hold
  always_comb begin
    unique case (cause_r)
      CAUSE_POWER: causeLive = monEn_r && !vddAbove;
      CAUSE_PIN:   causeLive = !rstPinIn;
      CAUSE_COMP:  causeLive = !compOut;
      default:     causeLive = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer and registers
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    cause_nxt   = cause_r;
    flags_nxt   = flags_r;
    holdCnt_nxt = holdCnt_r;
    monEn_nxt   = monEn_r;
    supSrc_nxt  = supSrc_r;
    clkEn_nxt   = clkEn_r;
    compSrc_nxt = compSrc_r;
    rdata_nxt   = rdata_r;
    if (sfrReq.rd) begin
      unique case (sfrReq.addr)
        MON_CTRL_ADDR: rdata_nxt = {monEn_r, vddAbove, 6'h00};
        CAUSE_ADDR:    rdata_nxt = {1'b0, flags_r};
        default:       rdata_nxt = 8'h00;
      endcase
    end
    unique case (state_r)
      ST_RUN: begin
        if (anyTrip) begin
          state_nxt   = ST_HOLD;
          cause_nxt   = tripCause;
          flags_nxt   = causeFlags(tripCause);
          holdCnt_nxt = HOLD_CYCLES;
        end else begin
          if (monWrite) begin
            monEn_nxt = sfrReq.wdata[MON_EN_BIT];
          end
          if (causeWrite) begin
            supSrc_nxt  = sfrReq.wdata[POWER_FLAG_BIT];
            clkEn_nxt   = sfrReq.wdata[CLK_LOSS_BIT];
            compSrc_nxt = sfrReq.wdata[COMP_BIT];
          end
        end
      end
      ST_HOLD: begin
        if (holdCnt_r != '0) begin
          holdCnt_nxt = holdCnt_r - HOLD_CNT_W'(1);
        end else if (!causeLive) begin
          state_nxt   = ST_RUN;
          clkEn_nxt   = 1'b0;
          compSrc_nxt = 1'b0;
        end
      end
    endcase
    pinOe_nxt  = (state_nxt == ST_HOLD) && (cause_nxt == CAUSE_POWER);
    sysRst_nxt = (state_nxt == ST_RUN);
  end

  // Power-on: held in reset, supply monitor enabled and selected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= ST_HOLD;
      cause_r   <= CAUSE_POWER;
      flags_r   <= 7'h02;
      holdCnt_r <= HOLD_CYCLES;
      monEn_r   <= MON_EN_RST;
      supSrc_r  <= SUPPLY_SRC_RST;
      clkEn_r   <= 1'b0;
      compSrc_r <= 1'b0;
      rdata_r   <= 8'h00;
      pinOe_r   <= 1'b1;
      sysRst_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cause_r   <= cause_nxt;
      flags_r   <= flags_nxt;
      holdCnt_r <= holdCnt_nxt;
      monEn_r   <= monEn_nxt;
      supSrc_r  <= supSrc_nxt;
      clkEn_r   <= clkEn_nxt;
      compSrc_r <= compSrc_nxt;
      rdata_r   <= rdata_nxt;
      pinOe_r   <= pinOe_nxt;
      sysRst_r  <= sysRst_nxt;
    end
  end

  assign sfrRdata  = rdata_r;
  assign rstPinOut = 1'b0;
  assign rstPinOe  = pinOe_r;
  assign sysResetn = sysRst_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seqSoftWrite;
    (state_r == ST_RUN) && causeWrite && sfrReq.wdata[SOFT_BIT] && !supplyTrip && !pinTrip
      && !lossPulse && !compTrip && !wdtOverflow && !flashFault;
  endsequence

  sequence seqHeldSoft;
    (state_r == ST_HOLD) && flags_r[SOFT_BIT] && !sysResetn && !rstPinOe;
  endsequence

  chk_supply_gate: assert property ((state_r == ST_RUN) && monEn_r && supSrc_r && !vddAbove
    |=> (state_r == ST_HOLD) && flags_r[POWER_FLAG_BIT])
    else $error("supply trip did not reset");
  chk_supply_ungated: assert property ((state_r == ST_RUN) && !supSrc_r && !pinTrip && !lossPulse
    && !compTrip && !wdtOverflow && !flashFault && !softTrip |=> state_r == ST_RUN)
    else $error("reset without selected source");
  chk_status_live: assert property (sfrReq.rd && (sfrReq.addr == MON_CTRL_ADDR)
    |=> (sfrRdata[SUPPLY_STAT_BIT] == $past(vddAbove)) && (sfrRdata[5:0] == 6'h00))
    else $error("monitor status read wrong");
  chk_mon_write: assert property ((state_r == ST_RUN) && !anyTrip && monWrite
    |=> monEn_r == $past(sfrReq.wdata[MON_EN_BIT]))
    else $error("monitor enable not written");
  chk_pin_flag: assert property ((state_r == ST_RUN) && pinTrip && !supplyTrip
    |=> (state_r == ST_HOLD) && (flags_r == 7'h01) && !rstPinOe)
    else $error("pin reset not flagged");
  chk_pin_quiet: assert property ((state_r == ST_HOLD) && (cause_r != CAUSE_POWER)
    |-> !rstPinOe)
    else $error("non-power reset drives pin");
  chk_power_drive: assert property ((state_r == ST_HOLD) && (cause_r == CAUSE_POWER)
    |-> rstPinOe && flags_r[POWER_FLAG_BIT])
    else $error("power reset not driving pin");
  chk_comp_trip: assert property ((state_r == ST_RUN) && compSrc_r && !compOut && !supplyTrip
    && !pinTrip && !lossPulse |=> flags_r == 7'h20)
    else $error("comparator reset not taken");
  chk_wdt_flag: assert property ((state_r == ST_RUN) && wdtOverflow && !supplyTrip && !pinTrip
    && !lossPulse && !compTrip |=> (state_r == ST_HOLD) && (flags_r == 7'h08))
    else $error("watchdog reset not flagged");
  chk_soft_force: assert property (seqSoftWrite |=> seqHeldSoft ##1 seqHeldSoft)
    else $error("software reset not forced");
  chk_flags_stable: assert property ((state_r == ST_RUN) && $past(state_r == ST_RUN)
    |-> $stable(flags_r))
    else $error("cause flags changed while running");
  chk_hold_min: assert property ($rose(state_r == ST_HOLD)
    |-> (state_r == ST_HOLD) [*5])
    else $error("reset released before minimum hold");

  // ---------------------------------------------------------------
  // Checks: trip flags, hold, exit and register access
  // ---------------------------------------------------------------
  chk_clk_flag: assert property ((state_r == ST_RUN) && lossPulse && !supplyTrip
    && !pinTrip |=> (state_r == ST_HOLD) && (flags_r == 7'h04))
    else $error("clock loss reset not flagged");
  chk_flash_flag: assert property ((state_r == ST_RUN) && flashFault && !supplyTrip
    && !pinTrip && !lossPulse && !compTrip && !wdtOverflow
    |=> (state_r == ST_HOLD) && (flags_r == 7'h40))
    else $error("flash reset not flagged");
  chk_hold_flags: assert property ((state_r == ST_HOLD) && $past(state_r == ST_HOLD)
    |-> $stable(flags_r))
    else $error("cause flags changed during reset");
  chk_one_flag: assert property ($onehot(flags_r))
    else $error("cause flags not exactly one");
  chk_exit_clear: assert property ($rose(state_r == ST_RUN)
    |-> !clkEn_r && !compSrc_r)
    else $error("source selects kept over reset exit");
  chk_supply_hold: assert property ((state_r == ST_HOLD) && (cause_r == CAUSE_POWER)
    && monEn_r && !vddAbove |=> state_r == ST_HOLD)
    else $error("supply reset released while low");
  chk_pin_hold: assert property ((state_r == ST_HOLD) && (cause_r == CAUSE_PIN)
    && !rstPinIn |=> state_r == ST_HOLD)
    else $error("pin reset released while pin low");
  chk_comp_hold: assert property ((state_r == ST_HOLD) && (cause_r == CAUSE_COMP)
    && !compOut |=> state_r == ST_HOLD)
    else $error("comparator reset released while low");
  chk_comp_select: assert property ((state_r == ST_RUN) && !anyTrip && causeWrite
    |=> compSrc_r == $past(sfrReq.wdata[COMP_BIT]))
    else $error("comparator select not written");
  chk_loss_select: assert property ((state_r == ST_RUN) && !anyTrip && causeWrite
    |=> clkEn_r == $past(sfrReq.wdata[CLK_LOSS_BIT]))
    else $error("clock loss enable not written");
  chk_hold_write: assert property ((state_r == ST_HOLD) && (monWrite || causeWrite)
    |=> $stable(monEn_r) && $stable(supSrc_r))
    else $error("register written during reset");
  chk_cause_read: assert property (sfrReq.rd && (sfrReq.addr == CAUSE_ADDR)
    |=> (sfrRdata[7] == 1'b0) && (sfrRdata[6:0] == $past(flags_r)))
    else $error("cause register read wrong");
  chk_unmapped_read: assert property (sfrReq.rd && (sfrReq.addr != MON_CTRL_ADDR)
    && (sfrReq.addr != CAUSE_ADDR) |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!sfrReq.rd |=> $stable(sfrRdata))
    else $error("read data changed without read");
endmodule

// ---- rsc_far_side.sv ----
// Far-side model: reset pin with pull-up, clock heartbeat, comparator and supply levels
`timescale 1ns/100ps
module rsc_far_side (
  input  wire logic clk,
  input  wire logic extLow,
  input  wire logic clkStop,
  input  wire logic compLowCmd,
  input  wire logic vddLowCmd,
  input  wire logic rstPinOut,
  input  wire logic rstPinOe,
  output logic      rstPinIn,
  output logic      clkHeartbeat,
  output logic      compOut,
  output logic      vddAbove
);
  // Pin rests high on its pull-up unless a party pulls it low
  assign rstPinIn = !(extLow || (rstPinOe && !rstPinOut));
  logic beat = 1'b0;
  // Heartbeat freezes while the monitored clock is lost
  always @(posedge clk) begin
    if (!clkStop) begin
      beat <= !beat;
    end
  end
  assign clkHeartbeat = beat;
  assign compOut  = !compLowCmd;
  assign vddAbove = !vddLowCmd;
endmodule

// ---- rsc_flash_guard.sv ----
// Flash access guard: flags illegal or forbidden flash accesses
`timescale 1ns/100ps
module rsc_flash_guard (
  input  wire logic           clk,
  input  wire logic           resetn,
  input  rsc_pkg::rsc_flash_req_t req,
  output logic                fault
);
  import rsc_pkg::*;

  logic fault_r;
  logic fault_nxt;

  always_comb begin
    fault_nxt = (req.wrStrobe && req.wrEnable && aboveUser(req.wrAddr))
             || (req.rdStrobe && aboveUser(req.rdAddr))
             || (req.fetchStrobe && aboveUser(req.fetchAddr))
             || req.secViolation;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign fault = fault_r;

  chk_flash_write: assert property (@(posedge clk) disable iff (!resetn)
    req.wrStrobe && req.wrEnable && (req.wrAddr > USER_CODE_TOP) |=> fault)
    else $error("flash write above user space not flagged");
  chk_flash_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !req.wrStrobe && !req.rdStrobe && !req.fetchStrobe && !req.secViolation |=> !fault)
    else $error("flash fault without access");
endmodule

// ---- rsc_pkg.sv ----
// Constants, types and helpers shared by the reset source controller
package rsc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_HOLD_NS = 100;
  localparam int HOLD_CNT_W    = 4;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CYCLES =
    HOLD_CNT_W'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int MCD_TIMEOUT_US = 100;
  localparam int MCD_CYCLES     = (MCD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int MCD_CNT_W      = 16;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] MON_CTRL_ADDR  = 8'hFF;
  localparam logic [7:0] CAUSE_ADDR     = 8'hEF;
  localparam int MON_EN_BIT      = 7;
  localparam int SUPPLY_STAT_BIT = 6;
  localparam int PIN_FLAG_BIT    = 0;
  localparam int POWER_FLAG_BIT  = 1;
  localparam int CLK_LOSS_BIT    = 2;
  localparam int WDT_FLAG_BIT    = 3;
  localparam int SOFT_BIT        = 4;
  localparam int COMP_BIT        = 5;
  localparam int FLASH_BIT       = 6;
  localparam logic MON_EN_RST     = 1'b1;
  localparam logic SUPPLY_SRC_RST = 1'b1;
  localparam logic [15:0] USER_CODE_TOP = 16'h3DFF;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_HOLD = 1'b1
  } rsc_state_t;

  typedef enum logic [2:0] {
    CAUSE_POWER = 3'h0,
    CAUSE_PIN   = 3'h1,
    CAUSE_CLK   = 3'h2,
    CAUSE_WDT   = 3'h3,
    CAUSE_SOFT  = 3'h4,
    CAUSE_COMP  = 3'h5,
    CAUSE_FLASH = 3'h6
  } rsc_cause_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rsc_sfr_req_t;

  typedef struct packed {
    logic        wrStrobe;
    logic        wrEnable;
    logic [15:0] wrAddr;
    logic        rdStrobe;
    logic [15:0] rdAddr;
    logic        fetchStrobe;
    logic [15:0] fetchAddr;
    logic        secViolation;
  } rsc_flash_req_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic aboveUser(input logic [15:0] addr);
    return addr > USER_CODE_TOP;
  endfunction

  function automatic logic [6:0] causeFlags(input rsc_cause_t cause);
    logic [6:0] f;
    f = 7'h00;
    unique case (cause)
      CAUSE_POWER: f[POWER_FLAG_BIT] = 1'b1;
      CAUSE_PIN:   f[PIN_FLAG_BIT]   = 1'b1;
      CAUSE_CLK:   f[CLK_LOSS_BIT]   = 1'b1;
      CAUSE_WDT:   f[WDT_FLAG_BIT]   = 1'b1;
      CAUSE_SOFT:  f[SOFT_BIT]       = 1'b1;
      CAUSE_COMP:  f[COMP_BIT]       = 1'b1;
      CAUSE_FLASH: f[FLASH_BIT]      = 1'b1;
      default:     f = 7'h00;
    endcase
    return f;
  endfunction

endpackage

// ---- test_rsc_controller.sv ----
// Self-checking bench for the reset source controller
`timescale 1ns/100ps
module test_rsc_controller;
  import rsc_pkg::*;
  localparam int LIMIT      = 20;
  localparam int MAX_CYCLES = 3000;
  logic           clk, resetn, rstPinIn, rstPinOut, rstPinOe, vddAbove, compOut;
  logic           wdtOverflow, clkHeartbeat, sysResetn;
  logic           extLow, clkStop, compLowCmd, vddLowCmd;
  logic [7:0]     sfrRdata;
  rsc_sfr_req_t   sfrReq;
  rsc_flash_req_t flashReq;
  rsc_flash_req_t bad [4];
  int             mismatches, check_count;
  int             cycles = 0;

  rsc_controller #(.MCD_LIMIT(LIMIT)) i_rsc_controller (
    .clk(clk), .resetn(resetn), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .vddAbove(vddAbove), .compOut(compOut), .wdtOverflow(wdtOverflow),
    .clkHeartbeat(clkHeartbeat), .flashReq(flashReq), .sysResetn(sysResetn));

  rsc_far_side i_rsc_far_side (
    .clk(clk), .extLow(extLow), .clkStop(clkStop), .compLowCmd(compLowCmd),
    .vddLowCmd(vddLowCmd), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .rstPinIn(rstPinIn), .clkHeartbeat(clkHeartbeat), .compOut(compOut),
    .vddAbove(vddAbove));

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      mismatches++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    sfrReq = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(negedge clk);
    sfrReq = '0;
  endtask

  task automatic sfr_rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk);
    sfrReq = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    sfrReq = '0;
    check(name, exp, sfrRdata);
  endtask

  task automatic flash_op(input rsc_flash_req_t req);
    @(negedge clk);
    flashReq = req;
    @(negedge clk);
    flashReq = '0;
  endtask

  // Waits a bounded time for the system reset output to reach a level
  task automatic wait_level(input logic lvl, input int lim, input string name);
    int n;
    n = 0;
    while (sysResetn !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(name, {7'h00, lvl}, {7'h00, sysResetn});
  endtask

  task automatic trip(input string name, input int lim, input logic oe);
    wait_level(1'b0, lim, name);
    @(negedge clk);
    check({name, " pin drive"}, {7'h00, oe}, {7'h00, rstPinOe});
  endtask

  task automatic recover(input string name, input logic [7:0] cause);
    wait_level(1'b1, 40, {name, " exit"});
    sfr_rd(name, CAUSE_ADDR, cause);
  endtask

  task automatic no_trip(input string name, input int n);
    logic seen;
    seen = 1'b1;
    repeat (n) begin
      @(negedge clk);
      seen = seen & sysResetn;
    end
    check(name, 8'h01, {7'h00, seen});
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    sfrReq = '0;
    flashReq = '0;
    wdtOverflow = 1'b0;
    extLow = 1'b0;
    clkStop = 1'b0;
    compLowCmd = 1'b0;
    vddLowCmd = 1'b0;
    mismatches = 0;
    check_count = 0;
    bad[0] = '{wrStrobe: 1'b1, wrEnable: 1'b1, wrAddr: 16'h3E00, default: '0};
    bad[1] = '{rdStrobe: 1'b1, rdAddr: 16'h3E00, default: '0};
    bad[2] = '{fetchStrobe: 1'b1, fetchAddr: 16'hFFFF, default: '0};
    bad[3] = '{rdStrobe: 1'b1, rdAddr: 16'h0100, secViolation: 1'b1, default: '0};
    repeat (8) @(negedge clk);
    check("power pin drive", 8'h01, {7'h00, rstPinOe});
    check("pin out level", 8'h00, {7'h00, rstPinOut});
    resetn = 1'b1;
    wait_level(1'b1, 40, "power exit");
    sfr_rd("cause after power", CAUSE_ADDR, 8'h02);
    sfr_rd("monitor control", MON_CTRL_ADDR, 8'hC0);
    sfr_rd("unmapped", 8'h87, 8'h00);
    sfr_wr(MON_CTRL_ADDR, 8'h3F);
    sfr_rd("monitor off", MON_CTRL_ADDR, 8'h40);
    sfr_wr(CAUSE_ADDR, 8'h02);
    vddLowCmd = 1'b1;
    sfr_rd("supply status low", MON_CTRL_ADDR, 8'h00);
    no_trip("disabled monitor", 10);
    vddLowCmd = 1'b0;
    sfr_wr(MON_CTRL_ADDR, 8'h80);
    // Monitor settles before it is selected as a source
    repeat (4) @(negedge clk);
    sfr_wr(CAUSE_ADDR, 8'h02);
    vddLowCmd = 1'b1;
    trip("supply", 4, 1'b1);
    repeat (8) @(negedge clk);
    vddLowCmd = 1'b0;
    recover("supply cause", 8'h02);
    sfr_wr(CAUSE_ADDR, 8'h10);
    trip("soft", 3, 1'b0);
    recover("soft cause", 8'h10);
    repeat (20) @(negedge clk);
    sfr_rd("cause held", CAUSE_ADDR, 8'h10);
    extLow = 1'b1;
    trip("pin", 3, 1'b0);
    repeat (3) @(negedge clk);
    extLow = 1'b0;
    recover("pin cause", 8'h01);
    @(negedge clk);
    wdtOverflow = 1'b1;
    @(negedge clk);
    wdtOverflow = 1'b0;
    trip("watchdog", 3, 1'b0);
    recover("watchdog cause", 8'h08);
    compLowCmd = 1'b1;
    no_trip("comparator unselected", 8);
    compLowCmd = 1'b0;
    sfr_wr(CAUSE_ADDR, 8'h20);
    compLowCmd = 1'b1;
    trip("comparator", 3, 1'b0);
    repeat (8) @(negedge clk);
    compLowCmd = 1'b0;
    recover("comparator cause", 8'h20);
    clkStop = 1'b1;
    no_trip("clock loss disabled", LIMIT + 8);
    clkStop = 1'b0;
    sfr_wr(CAUSE_ADDR, 8'h04);
    clkStop = 1'b1;
    trip("clock loss", LIMIT + 6, 1'b0);
    clkStop = 1'b0;
    recover("clock loss cause", 8'h04);
    flash_op('{wrStrobe: 1'b1, wrEnable: 1'b1, wrAddr: 16'h3DFF, rdStrobe: 1'b1,
               rdAddr: 16'h3DFF, fetchStrobe: 1'b1, fetchAddr: 16'h3DFF,
               secViolation: 1'b0});
    no_trip("flash boundary", 6);
    flash_op('{wrStrobe: 1'b1, wrAddr: 16'h3E00, default: '0});
    no_trip("flash write disabled", 6);
    for (int i = 0; i < 4; i++) begin
      flash_op(bad[i]);
      trip("flash", 4, 1'b0);
      recover("flash cause", 8'h40);
    end
    finish_test();
  end
endmodule
